// ===== rtl/tpi_pkg.sv
// Shared constants for the touch/proximity interrupt and status block.
// Assumes byte-wide device registers and a 32-bit Wishbone host port.
package tpi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int AVG_W = 12;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;

  // Device register offsets
  localparam logic [7:0] A_BOOST = 8'h1f;
  localparam logic [7:0] A_RES_A = 8'h20;
  localparam logic [7:0] A_RES_B = 8'h21;
  localparam logic [7:0] A_MASK = 8'h22;
  localparam logic [7:0] A_SRC = 8'h23;
  localparam logic [7:0] A_STAT = 8'h24;

  // Reset values
  localparam logic [7:0] RST_BOOST = 8'h00;
  localparam logic [7:0] RST_RES_A = 8'h01;
  localparam logic [7:0] RST_RES_B = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h08;
  localparam logic [7:0] RST_SRC = 8'h00;

  // Boost field
  localparam int BOOST_LSB = 3;
  localparam int BOOST_MSB = 5;
  localparam logic [2:0] BOOST_ON = 3'h4;
  localparam logic [2:0] BOOST_OFF = 3'h6;
  localparam logic [2:0] BOOST_LOW_FILL = 3'h4;
  localparam logic [7:0] BOOST_INIT = {2'h0, BOOST_OFF, BOOST_LOW_FILL};
  localparam logic [7:0] RES_A_PROG = 8'h81;

  // Source / mask bit positions
  localparam int B_MOTOR = 7;
  localparam int B_NEAR = 6;
  localparam int B_FAR = 5;
  localparam int B_CALIB = 4;
  localparam int B_STYLUS = 3;
  localparam int B_UP = 2;
  localparam int B_WARN = 1;
  localparam int B_ALARM = 0;

  // Status bit positions
  localparam int S_MOTOR = 7;
  localparam int S_RESET = 6;
  localparam int S_NEAR = 5;
  localparam int S_CALIB = 4;
  localparam int S_BUSY = 3;
  localparam int S_STYLUS = 2;
  localparam int S_WARN = 1;
  localparam int S_ALARM = 0;

  // Live vector order fed to the edge detector
  localparam int L_W = 7;
  localparam int L_MOTOR = 6;
  localparam int L_NEAR = 5;
  localparam int L_CALIB = 4;
  localparam int L_BUSY = 3;
  localparam int L_STYLUS = 2;
  localparam int L_WARN = 1;
  localparam int L_ALARM = 0;

  // Host Wishbone map
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam int CMD_WE_BIT = 16;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_IRQ_BIT = 9;
  localparam int ST_INIT_BIT = 10;
  localparam logic [3:0] CMD_SEL = 4'h7;

  typedef enum logic [2:0] {
    H_BOOT0 = 3'b000,
    H_WAIT0 = 3'b001,
    H_BOOT1 = 3'b010,
    H_WAIT1 = 3'b011,
    H_IDLE = 3'b100,
    H_BUSY = 3'b101
  } tpi_hstate_t;
endpackage

// ===== rtl/tpi_link_if.sv
// Register link between the host controller and the device end.
// Request held by the host until a one-cycle ack from the device.
`timescale 1ns/100ps
interface tpi_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic irq;

  modport dev (input req, input we, input addr, input wdata,
               output rdata, output ack, output irq);
  modport host (output req, output we, output addr, output wdata,
                input rdata, input ack, input irq);
endinterface

// ===== rtl/tpi_edge_det.sv
// Registers a live vector and reports rising and falling edges.
// Assumes the inputs are synchronous to clk_i.
`timescale 1ns/100ps
module tpi_edge_det #(
  parameter int W = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] live_i,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= live_i;
    end
  end

  assign rise_o = live_i & ~prev_r;
  assign fall_o = ~live_i & prev_r;
endmodule

// ===== rtl/tpi_device_end.sv
// Device end: interrupt mask, sources, live status and proximity config.
// Assumes all condition inputs are synchronous to clk_i.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
module tpi_device_end
  import tpi_pkg::*;
#(
  parameter int AW = AVG_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tpi_link_if.dev link,
  input wire logic motor_short_live_i,
  input wire logic near_object_raw_i,
  input wire logic [AW-1:0] near_sense_average_i,
  input wire logic calib_pending_live_i,
  input wire logic sampling_busy_live_i,
  input wire logic sampling_is_near_i,
  input wire logic stylus_down_live_i,
  input wire logic heat_warn_live_i,
  input wire logic heat_alarm_live_i,
  input wire logic far_or_done_select_i,
  input wire logic stylus_detect_operation_i,
  input wire logic heat_warn_edge_select_i,
  input wire logic heat_alarm_edge_select_i,
  input wire logic [3:0] side_pin_one_signal_select_i,
  output logic side_pin_o,
  output logic sense_gain_boost_o,
  output logic [7:0] proximity_reserved_a_o,
  output logic [AW-1:0] near_sense_average_o,
  output logic near_object_live_o,
  output logic calib_request_o
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  logic ack_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic [7:0] boost_r;
  logic [7:0] res_a_r;
  logic [7:0] mask_r;
  logic [7:0] src_r;
  logic reset_flag_r;
  logic near_r;
  logic [AW-1:0] avg_r;
  logic calib_flag_r;
  logic kind_near_r;
  logic side_pin_r;
  logic boost_on_r;
  logic calib_req_r;

  logic take;
  logic wr;
  logic rd;
  logic calib_stat;
  logic [L_W-1:0] live;
  logic [L_W-1:0] rise;
  logic [L_W-1:0] fall;
  logic [7:0] set_v;
  logic [7:0] status;

  // One request per held req; ack drops the cycle after it is given
  assign take = link.req && !ack_r;
  assign wr = take && link.we;
  assign rd = take && !link.we;

  assign calib_stat = calib_pending_live_i | calib_flag_r;

  assign status = {motor_short_live_i,
                   reset_flag_r,
                   near_r,
                   calib_stat,
                   sampling_busy_live_i,
                   stylus_down_live_i,
                   heat_warn_live_i,
                   heat_alarm_live_i};

  assign live = {motor_short_live_i, near_r, calib_stat, sampling_busy_live_i,
                 stylus_down_live_i, heat_warn_live_i, heat_alarm_live_i};

  tpi_edge_det #(.W(L_W)) u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .live_i(live),
    .rise_o(rise),
    .fall_o(fall)
  );

  always_comb begin
    set_v = '0;
    set_v[B_MOTOR] = rise[L_MOTOR];
    set_v[B_NEAR] = rise[L_NEAR];
    set_v[B_FAR] = far_or_done_select_i ? (fall[L_BUSY] && kind_near_r)
                                        : fall[L_NEAR];
    set_v[B_CALIB] = fall[L_CALIB];
    set_v[B_STYLUS] = stylus_detect_operation_i ? rise[L_STYLUS]
                                                : (fall[L_BUSY] && !kind_near_r);
    set_v[B_UP] = fall[L_STYLUS];
    set_v[B_WARN] = heat_warn_edge_select_i ? rise[L_WARN] : fall[L_WARN];
    set_v[B_ALARM] = heat_alarm_edge_select_i ? rise[L_ALARM] : fall[L_ALARM];
  end

  // Remembers which kind of conversion was last running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_near_r <= 1'b0;
    end else if (sampling_busy_live_i) begin
      kind_near_r <= sampling_is_near_i;
    end
  end

  // No haptics input: proximity tracking is never paused by the motor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      near_r <= 1'b0;
      avg_r <= '0;
    end else if (!stylus_down_live_i) begin
      near_r <= near_object_raw_i;
      avg_r <= near_sense_average_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= take;
      if (rd) begin
        case (link.addr)
          A_BOOST: rdata_r <= boost_r;
          A_RES_A: rdata_r <= res_a_r;
          A_RES_B: rdata_r <= RST_RES_B;
          A_MASK: rdata_r <= mask_r;
          A_SRC: rdata_r <= src_r;
          A_STAT: rdata_r <= status;
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // Reserved register B is not writable and always reads its reset value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_r <= RST_BOOST;
      res_a_r <= RST_RES_A;
      mask_r <= RST_MASK;
    end else if (wr) begin
      if (hit(link.addr, A_BOOST)) begin
        boost_r <= link.wdata;
      end
      if (hit(link.addr, A_RES_A)) begin
        res_a_r <= link.wdata;
      end
      if (hit(link.addr, A_MASK)) begin
        mask_r <= link.wdata;
      end
    end
  end

  // A new edge in the read cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_r <= RST_SRC;
    end else if (rd && hit(link.addr, A_SRC)) begin
      src_r <= set_v;
    end else begin
      src_r <= src_r | set_v;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_flag_r <= 1'b1;
    end else if (rd && hit(link.addr, A_STAT)) begin
      reset_flag_r <= 1'b0;
    end
  end

  // Flag bridges the gap until the front end reports the request pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      calib_flag_r <= 1'b0;
      calib_req_r <= 1'b0;
    end else begin
      calib_req_r <= wr && hit(link.addr, A_STAT) && link.wdata[S_CALIB];
      if (wr && hit(link.addr, A_STAT) && link.wdata[S_CALIB]) begin
        calib_flag_r <= 1'b1;
      end else if (calib_pending_live_i) begin
        calib_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
      side_pin_r <= 1'b0;
      boost_on_r <= 1'b0;
    end else begin
      irq_r <= |(src_r & mask_r);
      side_pin_r <= side_pin_one_signal_select_i[3]
                    ? status[side_pin_one_signal_select_i[2:0]]
                    : src_r[side_pin_one_signal_select_i[2:0]];
      boost_on_r <= (boost_r[BOOST_MSB:BOOST_LSB] == BOOST_ON);
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign link.irq = irq_r;
  assign side_pin_o = side_pin_r;
  assign sense_gain_boost_o = boost_on_r;
  assign proximity_reserved_a_o = res_a_r;
  assign near_sense_average_o = avg_r;
  assign near_object_live_o = near_r;
  assign calib_request_o = calib_req_r;
endmodule

// ===== rtl/tpi_host_end.sv
// Host end: programs the device after reset, then relays software
// commands from a classic Wishbone slave port onto the register link.
`timescale 1ns/100ps
module tpi_host_end
  import tpi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  tpi_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  tpi_hstate_t state_r;
  logic req_r;
  logic we_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic wb_ack_r;
  logic [WB_DW-1:0] wb_dat_r;
  logic irq_r;
  logic go;

  // Command write takes effect at the edge where ack is seen
  assign go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r && (wb_adr_i == WB_CMD)
              && ((wb_sel_i & CMD_SEL) == CMD_SEL) && (state_r == H_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
      irq_r <= link.irq;
      if (wb_cyc_i && wb_stb_i && !wb_ack_r) begin
        wb_dat_r <= '0;
        if (wb_adr_i == WB_STAT) begin
          wb_dat_r[7:0] <= rdata_r;
          wb_dat_r[ST_BUSY_BIT] <= (state_r != H_IDLE);
          wb_dat_r[ST_IRQ_BIT] <= irq_r;
          wb_dat_r[ST_INIT_BIT] <= (state_r == H_IDLE) || (state_r == H_BUSY);
        end
      end
    end
  end

  // Boot writes: boost off with fill pattern, then the reserved value;
  // boost stays off since the panel may be the sensor. Scan pausing is
  // left to software through ordinary commands.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= H_BOOT0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      case (state_r)
        H_BOOT0: begin
          req_r <= 1'b1;
          we_r <= 1'b1;
          addr_r <= A_BOOST;
          wdata_r <= BOOST_INIT;
          state_r <= H_WAIT0;
        end
        H_WAIT0: begin
          if (link.ack) begin
            req_r <= 1'b0;
            state_r <= H_BOOT1;
          end
        end
        H_BOOT1: begin
          req_r <= 1'b1;
          we_r <= 1'b1;
          addr_r <= A_RES_A;
          wdata_r <= RES_A_PROG;
          state_r <= H_WAIT1;
        end
        H_WAIT1: begin
          if (link.ack) begin
            req_r <= 1'b0;
            state_r <= H_IDLE;
          end
        end
        H_IDLE: begin
          if (go) begin
            req_r <= 1'b1;
            we_r <= wb_dat_i[CMD_WE_BIT];
            addr_r <= wb_dat_i[15:8];
            wdata_r <= wb_dat_i[7:0];
            state_r <= H_BUSY;
          end
        end
        H_BUSY: begin
          if (link.ack) begin
            req_r <= 1'b0;
            if (!we_r) begin
              rdata_r <= link.rdata;
            end
            state_r <= H_IDLE;
          end
        end
        default: begin
          req_r <= 1'b0;
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  assign link.req = req_r;
  assign link.we = we_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign irq_o = irq_r;
endmodule

// ===== test/tpi_properties.sv
// Checker for the register link between the host end and the device end.
// Sees only the link signals; instantiated by the bench beside the link.
`timescale 1ns/100ps
module tpi_link_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic irq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic clr;
  // Only an acknowledged source or mask access, read or write, may take the interrupt request line down
  assign clr = ack && (addr == 8'h23 || addr == 8'h22);
  sequence s_boost;
    req && we && addr == 8'h1f && wdata == 8'h34;
  endsequence
  sequence s_prog;
    req && we && addr == 8'h20 && wdata == 8'h81;
  endsequence
  property p_boot;
    $fell(rst_i) |-> ##[0:2] s_boost ##[1:6] s_prog;
  endproperty
  property p_pulse;
    ack |=> !ack;
  endproperty
  property p_answer;
    req && !ack |=> ack;
  endproperty
  property p_cause;
    ack |-> req;
  endproperty
  property p_hold;
    req && !ack |=> $stable(we) && $stable(addr) && $stable(wdata);
  endproperty
  property p_release;
    ack |=> !req;
  endproperty
  property p_rdata;
    $changed(rdata) |-> ack && !we;
  endproperty
  property p_unmap;
    ack && !we && (addr < 8'h1f || addr == 8'h21 || addr > 8'h24) |-> rdata == 8'h00;
  endproperty
  property p_irq_clr;
    $fell(irq) |-> $past(clr) || $past(clr, 2);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot writes missing");
  a_pulse: assert property (p_pulse)
    else $error("ack longer than one cycle");
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");
  a_cause: assert property (p_cause)
    else $error("ack without request");
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  a_release: assert property (p_release)
    else $error("request kept after ack");
  a_rdata: assert property (p_rdata)
    else $error("read data changed outside a read");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  a_irq_clr: assert property (p_irq_clr)
    else $error("irq dropped without clear");
endmodule

// ===== test/touch_prox_irq_status_tb.sv
// Bench for both ends joined by the link; software traffic over Wishbone.
// Assumes the host end boots the device by itself after reset.
`timescale 1ns/100ps
module touch_prox_irq_status_tb;
  import tpi_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq, boost, calreq, pin, near_live;
  logic [3:0] wb_sel, cfg, psel;
  logic [7:0] wb_adr, lv, res_a;
  logic [31:0] wb_wd, wb_rd, q;
  logic [11:0] avg, avg_o;
  logic nf;
  logic [7:0] msk;
  int num_errors = 0;
  int n_checks = 0;
  int ncal = 0;
  int k;
  logic [7:0] la [22] = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h20, 8'h00, 8'h04, 8'h00, 8'h03,
    8'h00, 8'h03, 8'h00, 8'h18, 8'h00, 8'h10, 8'h00, 8'h40, 8'h00, 8'h04, 8'h44, 8'h40, 8'h00};
  logic [7:0] ea [22] = '{8'h80, 8'h00, 8'h40, 8'h20, 8'h00, 8'h10, 8'h08, 8'h04, 8'h03,
    8'h00, 8'h00, 8'h03, 8'h00, 8'h20, 8'h00, 8'h08, 8'h40, 8'h00, 8'h00, 8'h00, 8'h44, 8'h20};
  tpi_link_if link ();
  tpi_host_end u_tpi_host_end (.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wd),
    .wb_sel_i(wb_sel), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .irq_o(irq));
  tpi_device_end u_tpi_device_end (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .motor_short_live_i(lv[7]), .near_object_raw_i(lv[6]), .near_sense_average_i(avg),
    .calib_pending_live_i(lv[5]), .sampling_busy_live_i(lv[4]), .sampling_is_near_i(lv[3]),
    .stylus_down_live_i(lv[2]), .heat_warn_live_i(lv[1]), .heat_alarm_live_i(lv[0]),
    .far_or_done_select_i(cfg[3]), .stylus_detect_operation_i(cfg[2]),
    .heat_warn_edge_select_i(cfg[1]), .heat_alarm_edge_select_i(cfg[0]),
    .side_pin_one_signal_select_i(psel), .side_pin_o(pin), .sense_gain_boost_o(boost),
    .proximity_reserved_a_o(res_a), .near_sense_average_o(avg_o),
    .near_object_live_o(near_live), .calib_request_o(calreq));
  tpi_link_properties u_tpi_link_properties (.clk_i(clk_i), .rst_i(rst_i), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .ack(link.ack), .irq(link.irq));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (calreq === 1'b1) ncal <= ncal + 1;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; the slave's latency is never assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dw);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wd <= dw;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack !== 1'b1 && i < 40);
    if (wb_ack !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic poll(input int b, input logic v);
    int i;
    i = 0;
    do begin
      wb(1'b0, WB_STAT, 32'h0);
      i++;
    end while (q[b] !== v && i < 40);
    if (q[b] !== v) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic lnk(input logic w, input logic [7:0] a, input logic [7:0] dw);
    wb(1'b1, WB_CMD, {15'h0, w, a, dw});
    poll(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    lnk(1'b0, a, 8'h00);
    chk({24'h0, q[7:0]}, {24'h0, e});
  endtask
  // Near status is modelled frozen while the pen is down
  task automatic ev(input logic [7:0] l, input logic [7:0] e);
    @(posedge clk_i);
    lv <= l;
    if (!l[2]) nf = l[6];
    repeat (5) @(posedge clk_i);
    chk(irq, |(e & msk));
    chk(pin, e[psel[2:0]]);
    chk(near_live, nf);
    // Host status word mirrors the interrupt request line
    wb(1'b0, WB_STAT, 32'h0);
    chk(q[ST_IRQ_BIT], |(e & msk));
    rd(A_SRC, e);
    rd(A_STAT, {l[7], 1'b0, nf, l[5], l[4], l[2], l[1], l[0]});
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wd} = '0;
    wb_sel = 4'hf;
    lv = 8'h00;
    nf = 1'b0;
    cfg = 4'h7;
    psel = 4'h7;
    avg = 12'h123;
    msk = RST_MASK;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    poll(ST_INIT_BIT, 1'b1);
    rd(A_BOOST, 8'h34);
    chk(boost, 1'b0);
    chk(res_a, RES_A_PROG);
    rd(A_RES_A, 8'h81);
    rd(A_RES_B, 8'h00);
    rd(A_MASK, 8'h08);
    rd(A_SRC, 8'h00);
    rd(A_STAT, 8'h40);
    rd(A_STAT, 8'h00);
    rd(8'h30, 8'h00);
    $display("test reset values done");
    lnk(1'b1, A_BOOST, 8'h24);
    chk(boost, 1'b1);
    lnk(1'b1, A_BOOST, BOOST_INIT);
    lnk(1'b1, A_RES_B, 8'h55);
    rd(A_RES_B, 8'h00);
    msk = 8'hf5;
    lnk(1'b1, A_MASK, msk);
    rd(A_MASK, 8'hf5);
    $display("test register access done");
    for (k = 0; k < 22; k++) begin
      if (k == 10) cfg <= 4'h8;
      if (k == 10) psel <= 4'h0;
      if (k == 18) cfg <= 4'h0;
      if (k == 18) psel <= 4'h5;
      if (k == 19) avg <= 12'h456;
      ev(la[k], ea[k]);
      if (k == 19) chk(avg_o, 12'h123);
    end
    chk(avg_o, 12'h456);
    $display("test events done");
    lnk(1'b1, A_STAT, 8'h10);
    chk(ncal, 1);
    rd(A_STAT, 8'h10);
    // Select code 1xxx routes a status bit, here the pending calibration
    psel <= 4'hc;
    repeat (3) @(posedge clk_i);
    chk(pin, 1'b1);
    psel <= 4'h5;
    ev(8'h20, 8'h00);
    ev(8'h00, 8'h10);
    $display("test calibration request done");
    end_of_test();
  end
endmodule
